// ### core/positioning_point_table.v
// Notes on behaviour
// - table holds exactly 99 positioning entries
// - entries addressed by number 1 through 99
// - host gives entry then start launches motion
// - target position signed, plus/minus two billion
// - speed field in 0.01 r/min steps
// - dwell 0.001 s or 0.01 s steps
// - absolute or incremental command flag per entry
// - step mode: chain next or finish
// - aux code enable, 8-bit value, timing select
// - separate decimal scaling setting for position, dwell; here one scale_q, stored and read back but never applied
// - scaling 0..5, default 0, always writable
// - gear numerator 1..4194304, default 16
// - gear denominator 1..4194304, default 1
// - table only in positioning variant; here only starts are refused without it, table writes and reads still work
`timescale 1ns/100ps
`default_nettype none
`include "point_table_consts.vh"
module positioning_point_table #(
   parameter ENTRIES = 99
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite slave
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // host start interface (pins)
   input wire [6:0] start_entry,
   input wire start_positioning,
   input wire positioning_variant,
   // launched motion
   output reg motion_start_q,
   output reg [6:0] motion_entry_q,
   output reg start_reject_q
);
   reg [31:0] pos_mem [1:ENTRIES];
   reg [31:0] spd_mem [1:ENTRIES];
   reg [15:0] dwl_mem [1:ENTRIES];
   reg [15:0] flg_mem [1:ENTRIES];
   reg [6:0] sel_q;
   reg [31:0] pos_q, spd_q;
   reg [15:0] dwl_q, flg_q;
   reg [2:0] scale_q;
   reg [22:0] gnum_q, gden_q;
   reg [31:0] act_pos_q, act_spd_q;
   reg [15:0] act_dwl_q, act_flg_q;
   reg signed [63:0] act_tgt_q;
   reg [6:0] ent_s1_q, ent_s2_q;
   reg st_s1_q, st_s2_q, st_old_q, var_s1_q, var_s2_q;
   reg [11:0] awaddr_q, araddr_q;
   reg [31:0] wdata_q;
   reg aw_have_q, w_have_q;
   reg bad_write_q;
   reg [1:0] ld_q;
   reg [6:0] ld_entry_q;

   // load sequencer states
   localparam LD_IDLE = 2'h0;
   localparam LD_FETCH = 2'h1;
   localparam LD_SCALE = 2'h2;

   function entry_ok;
      input [6:0] n;
      begin
         entry_ok = (n >= `ENTRY_FIRST) && (n <= `ENTRY_LAST) && (n <= ENTRIES);
      end
   endfunction

   function gear_ok;
      input [31:0] v;
      begin
         gear_ok = (v != 32'h0000_0000) && (v <= {9'h000, `GEAR_MAX});
      end
   endfunction

   function pos_ok;
      input [31:0] v;
      begin
         pos_ok = ($signed(v) <= $signed(`POS_MAX)) && ($signed(v) >= $signed(`POS_MIN));
      end
   endfunction

   // pin inputs pass two flops first
   always @(posedge aclk) begin
      if (!aresetn) begin
         ent_s1_q <= 7'h00;
         ent_s2_q <= 7'h00;
         st_s1_q <= 1'b0;
         st_s2_q <= 1'b0;
         st_old_q <= 1'b0;
         var_s1_q <= 1'b0;
         var_s2_q <= 1'b0;
      end else begin
         ent_s1_q <= start_entry;
         ent_s2_q <= ent_s1_q;
         st_s1_q <= start_positioning;
         st_s2_q <= st_s1_q;
         st_old_q <= st_s2_q;
         var_s1_q <= positioning_variant;
         var_s2_q <= var_s1_q;
      end
   end

   wire start_edge = st_s2_q & ~st_old_q;
   wire do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
   wire flags_legal = ~(wdata_q[`FLG_CHAIN] & wdata_q[`FLG_FINISH]);

   // write channel: address and data in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h0000_0000;
         sel_q <= `ENTRY_FIRST;
         pos_q <= 32'h0000_0000;
         spd_q <= 32'h0000_0000;
         dwl_q <= 16'h0000;
         flg_q <= 16'h0000;
         scale_q <= `SCALE_RESET;
         gnum_q <= `GNUM_RESET;
         gden_q <= `GDEN_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            // out-of-range values are refused with slverr, old value kept
            case ({awaddr_q[11:2], 2'b00})
               `REG_SEL: if (entry_ok(wdata_q[6:0]) && wdata_q[31:7] == 25'h0) begin
                  sel_q <= wdata_q[6:0];
               end else begin
                  s_axi_bresp <= 2'b10;
               end
               `REG_POS: if (pos_ok(wdata_q)) begin
                  pos_q <= wdata_q;
               end else begin
                  s_axi_bresp <= 2'b10;
               end
               `REG_SPEED: spd_q <= wdata_q;
               `REG_DWELL: dwl_q <= wdata_q[15:0];
               `REG_FLAGS: if (flags_legal) begin
                  flg_q <= wdata_q[15:0];
               end else begin
                  s_axi_bresp <= 2'b10;
               end
               `REG_COMMIT: s_axi_bresp <= 2'b00;
               `REG_SCALE: if (wdata_q[2:0] <= `SCALE_MAX && wdata_q[31:3] == 29'h0) begin
                  scale_q <= wdata_q[2:0];
               end else begin
                  s_axi_bresp <= 2'b10;
               end
               `REG_GNUM: if (gear_ok(wdata_q)) begin
                  gnum_q <= wdata_q[22:0];
               end else begin
                  s_axi_bresp <= 2'b10;
               end
               `REG_GDEN: if (gear_ok(wdata_q)) begin
                  gden_q <= wdata_q[22:0];
               end else begin
                  s_axi_bresp <= 2'b10;
               end
               `REG_CTRL, `REG_STATUS: s_axi_bresp <= 2'b00;
               default: s_axi_bresp <= 2'b10;
            endcase
         end
      end
   end

   // commit the staged entry into the table
   wire commit = do_write && ({awaddr_q[11:2], 2'b00} == `REG_COMMIT);

   always @(posedge aclk) begin
      if (commit) begin
         pos_mem[sel_q] <= pos_q;
         spd_mem[sel_q] <= spd_q;
         dwl_mem[sel_q] <= dwl_q;
         flg_mem[sel_q] <= flg_q;
      end
   end

   // start: fetch entry, then scale target
   always @(posedge aclk) begin
      if (!aresetn) begin
         ld_q <= LD_IDLE;
         ld_entry_q <= 7'h00;
         motion_start_q <= 1'b0;
         motion_entry_q <= 7'h00;
         start_reject_q <= 1'b0;
         act_pos_q <= 32'h0000_0000;
         act_spd_q <= 32'h0000_0000;
         act_dwl_q <= 16'h0000;
         act_flg_q <= 16'h0000;
         act_tgt_q <= 64'h0;
      end else begin
         motion_start_q <= 1'b0;
         start_reject_q <= 1'b0;
         case (ld_q)
            LD_IDLE: if (start_edge) begin
               if (var_s2_q && entry_ok(ent_s2_q)) begin
                  ld_entry_q <= ent_s2_q;
                  ld_q <= LD_FETCH;
               end else begin
                  start_reject_q <= 1'b1;
               end
            end
            LD_FETCH: begin
               act_pos_q <= pos_mem[ld_entry_q];
               act_spd_q <= spd_mem[ld_entry_q];
               act_dwl_q <= dwl_mem[ld_entry_q];
               act_flg_q <= flg_mem[ld_entry_q];
               ld_q <= LD_SCALE;
            end
            LD_SCALE: begin
               // divide is combinational; one motion per start keeps it off hot paths
               act_tgt_q <= ($signed({{32{act_pos_q[31]}}, act_pos_q}) *
                  $signed({41'h0, gnum_q})) / $signed({41'h0, gden_q});
               motion_entry_q <= ld_entry_q;
               motion_start_q <= 1'b1;
               ld_q <= LD_IDLE;
            end
            default: ld_q <= LD_IDLE;
         endcase
      end
   end

   // read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case ({s_axi_araddr[11:2], 2'b00})
            `REG_CTRL: s_axi_rdata <= 32'h0000_0000;
            `REG_STATUS: s_axi_rdata <= {29'h0, var_s2_q, ld_q != LD_IDLE, st_s2_q};
            `REG_SEL: s_axi_rdata <= {25'h0, sel_q};
            `REG_POS: s_axi_rdata <= pos_q;
            `REG_SPEED: s_axi_rdata <= spd_q;
            `REG_DWELL: s_axi_rdata <= {16'h0, dwl_q};
            `REG_FLAGS: s_axi_rdata <= {16'h0, flg_q};
            `REG_COMMIT: s_axi_rdata <= 32'h0000_0000;
            `REG_SCALE: s_axi_rdata <= {29'h0, scale_q};
            `REG_GNUM: s_axi_rdata <= {9'h0, gnum_q};
            `REG_GDEN: s_axi_rdata <= {9'h0, gden_q};
            `REG_ACT_ENTRY: s_axi_rdata <= {25'h0, motion_entry_q};
            `REG_ACT_TARGET: s_axi_rdata <= act_tgt_q[31:0];
            `REG_ACT_SPEED: s_axi_rdata <= act_spd_q;
            `REG_ACT_DWELL: s_axi_rdata <= {16'h0, act_dwl_q};
            `REG_ACT_FLAGS: s_axi_rdata <= {16'h0, act_flg_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end
   end
endmodule // positioning_point_table
`default_nettype wire

// ### core/point_table_consts.vh
`ifndef POINT_TABLE_CONSTS_VH
`define POINT_TABLE_CONSTS_VH
// register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_SEL 12'h008
`define REG_POS 12'h00C
`define REG_SPEED 12'h010
`define REG_DWELL 12'h014
`define REG_FLAGS 12'h018
`define REG_COMMIT 12'h01C
`define REG_SCALE 12'h020
`define REG_GNUM 12'h024
`define REG_GDEN 12'h028
`define REG_ACT_ENTRY 12'h02C
`define REG_ACT_TARGET 12'h030
`define REG_ACT_SPEED 12'h034
`define REG_ACT_DWELL 12'h038
`define REG_ACT_FLAGS 12'h03C
// entry flag field positions
`define FLG_ABSOLUTE 0
`define FLG_CHAIN 1
`define FLG_FINISH 2
`define FLG_MEN 3
`define FLG_MAT_END 4
`define FLG_DWELL_FINE 5
`define FLG_MCODE_LO 8
`define FLG_MCODE_HI 15
// table limits and reset values
`define ENTRY_FIRST 7'h01
`define ENTRY_LAST 7'h63
`define POS_MAX 32'h7735_9400
`define POS_MIN 32'h88CA_6C00
`define GEAR_MAX 23'h40_0000
`define GNUM_RESET 23'h00_0010
`define GDEN_RESET 23'h00_0001
`define SCALE_RESET 3'h0
`define SCALE_MAX 3'h5
`endif

// ### verif/pt_checker_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module pt_checker #(
   parameter ENTRIES = 99
) (
   input wire aclk,
   input wire aresetn,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire positioning_variant,
   input wire motion_start_q,
   input wire [6:0] motion_entry_q,
   input wire start_reject_q
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   // byte lanes of the last word still decode to it, so compare word indices
   hole_read_a: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[11:2] > 10'h00F
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   launch_pulse_a: assert property (motion_start_q |=> !motion_start_q)
      else $error("launch pulse longer than one cycle");
   entry_range_a: assert property (motion_start_q
      |-> motion_entry_q >= 7'h01 && motion_entry_q <= ENTRIES)
      else $error("launch with entry outside table");
   launch_excl_a: assert property (!(motion_start_q && start_reject_q))
      else $error("launch and reject together");
   variant_gate_a: assert property (!positioning_variant [*8] |-> !motion_start_q)
      else $error("launch without positioning variant");
   cover property (motion_start_q);
   cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
   cover property (start_reject_q);
   cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // pt_checker
bind positioning_point_table pt_checker #(.ENTRIES(ENTRIES)) chk_u (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .positioning_variant(positioning_variant),
   .motion_start_q(motion_start_q), .motion_entry_q(motion_entry_q),
   .start_reject_q(start_reject_q));
`default_nettype wire

// ### verif/start_host.sv
`timescale 1ns/100ps
`default_nettype none
module start_host (
   input wire logic aclk,
   output logic [6:0] start_entry,
   output logic start_positioning
);
   initial begin
      start_entry = 7'h01;
      start_positioning = 1'b0;
   end
   // entry settles before the edge so both sync stages agree on one value
   task drive(input logic [6:0] e, input int lead);
      @(posedge aclk);
      start_entry <= e;
      repeat (lead + 3) @(posedge aclk);
      start_positioning <= 1'b1;
      repeat (6) @(posedge aclk);
      start_positioning <= 1'b0;
   endtask
endmodule // start_host
`default_nettype wire

// ### verif/tb_positioning_point_table.sv
`timescale 1ns/100ps
`default_nettype none
`include "point_table_consts.vh"
module tb_positioning_point_table;
   logic aclk = 0, aresetn = 0, variant = 1;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   wire awready, wready, bvalid, arready, rvalid, start_pos, motion_start_q, start_reject_q;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [6:0] start_entry, motion_entry_q;
   int errors = 0, check_count = 0, cyc = 0;
   always #10 aclk = ~aclk;
   positioning_point_table dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .start_entry(start_entry), .start_positioning(start_pos),
      .positioning_variant(variant), .motion_start_q(motion_start_q),
      .motion_entry_q(motion_entry_q), .start_reject_q(start_reject_q));
   start_host host_u (.aclk(aclk), .start_entry(start_entry), .start_positioning(start_pos));
   task stop_test;
      if (errors == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors = errors + 1;
         stop_test;
      end
   end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", {30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk("rresp", {30'h0, rresp}, {30'h0, er});
      chk("rdata", rdata, d);
      @(posedge aclk);
   endtask
   task launch(input logic [6:0] e, input int lead, input logic ok);
      logic g, r;
      g = 0;
      r = 0;
      fork
         host_u.drive(e, lead);
         repeat (40) begin
            @(posedge aclk);
            g = g | motion_start_q;
            r = r | start_reject_q;
         end
      join
      chk("launch", {31'h0, g}, {31'h0, ok});
      chk("reject", {31'h0, r}, {31'h0, !ok});
      if (ok) chk("entry", {25'h0, motion_entry_q}, {25'h0, e});
   endtask
   task t_defaults;
      rd(`REG_SCALE, 32'h0000_0000, 2'b00);
      rd(`REG_GNUM, 32'h0000_0010, 2'b00);
      rd(`REG_GDEN, 32'h0000_0001, 2'b00);
   endtask
   task t_limits;
      wr(`REG_SCALE, 32'h0000_0005, 2'b00);
      wr(`REG_SCALE, 32'h0000_0006, 2'b10);
      rd(`REG_SCALE, 32'h0000_0005, 2'b00);
      wr(`REG_GNUM, 32'h0040_0000, 2'b00);
      wr(`REG_GNUM, 32'h0040_0001, 2'b10);
      wr(`REG_GNUM, 32'h0000_0000, 2'b10);
      rd(`REG_GNUM, 32'h0040_0000, 2'b00);
      wr(`REG_GDEN, 32'h0000_0000, 2'b10);
      wr(`REG_GDEN, 32'h0040_0001, 2'b10);
      rd(`REG_GDEN, 32'h0000_0001, 2'b00);
      wr(`REG_GNUM, 32'h0000_0003, 2'b00);
      wr(`REG_GDEN, 32'h0000_0002, 2'b00);
   endtask
   task t_table;
      wr(`REG_SEL, 32'h0000_0000, 2'b10);
      wr(`REG_SEL, 32'h0000_0064, 2'b10);
      wr(`REG_SEL, 32'h0000_0063, 2'b00);
      wr(`REG_POS, 32'h7735_9401, 2'b10);
      wr(`REG_POS, 32'h88CA_6C00, 2'b00);
      wr(`REG_POS, 32'hFFFF_FC18, 2'b00);
      wr(`REG_SPEED, 32'h0000_0001, 2'b00);
      wr(`REG_DWELL, 32'h0000_FFFF, 2'b00);
      wr(`REG_FLAGS, 32'h0000_0006, 2'b10);
      wr(`REG_FLAGS, 32'h0000_FF3D, 2'b00);
      wr(`REG_COMMIT, 32'h0000_0001, 2'b00);
      wr(`REG_SEL, 32'h0000_0001, 2'b00);
      wr(`REG_POS, 32'h0000_03E8, 2'b00);
      wr(`REG_FLAGS, 32'h0000_0002, 2'b00);
      wr(`REG_COMMIT, 32'h0000_0001, 2'b00);
   endtask
   task t_launch;
      launch(7'h63, 0, 1'b1);
      rd(`REG_ACT_TARGET, 32'hFFFF_FA24, 2'b00);
      rd(`REG_ACT_SPEED, 32'h0000_0001, 2'b00);
      rd(`REG_ACT_DWELL, 32'h0000_FFFF, 2'b00);
      rd(`REG_ACT_FLAGS, 32'h0000_FF3D, 2'b00);
      launch(7'h01, 10, 1'b1);
      rd(`REG_ACT_TARGET, 32'h0000_05DC, 2'b00);
      rd(`REG_ACT_FLAGS, 32'h0000_0002, 2'b00);
   endtask
   task t_reject;
      launch(7'h64, 0, 1'b0);
      launch(7'h00, 0, 1'b0);
      rd(`REG_ACT_ENTRY, 32'h0000_0001, 2'b00);
      variant <= 1'b0;
      launch(7'h63, 5, 1'b0);
      variant <= 1'b1;
      rd(12'h100, 32'h0000_0000, 2'b10);
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_defaults;
      t_limits;
      t_table;
      t_launch;
      t_reject;
      stop_test;
   end
endmodule // tb_positioning_point_table
`default_nettype wire
